/* shared/rtc_pkg.sv */
// How it works
// - time base comes from 32.768 kHz crystal
// - time counters cleared only by power-on reset
// - clock keeps running in power saving modes
// - midnight flag set at rollover, software clears
// - day wrap mode picks 23 or 255
// - day wrap mode cleared only by power-on
// - timebase field picks tick, second, minute, hour
// - single shot stops after one alarm
// - alarm flag set on interval, software clears
// - interval disabled holds count at zero
// - interval runs only with both enables
// - clock enable resets to one, gates strobes
// - fraction ticks wrap 127, bump seconds
// - seconds wrap 59, bump minutes
// - minutes wrap 59, bump hours
// - hour wrap sets midnight and interrupt
// - count equal target sets alarm, interrupt
// - interval counter is eight bits
// - time registers reset only at power-on
// - nominal trim holds compensation at 25 C
package rtc_pkg;
  // ----------------------------------------
  // register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00_A1;
  localparam logic [7:0] ADDR_FRACTION = 8'h00_A2;
  localparam logic [7:0] ADDR_SECONDS = 8'h00_A3;
  localparam logic [7:0] ADDR_MINUTES = 8'h00_A4;
  localparam logic [7:0] ADDR_HOURS = 8'h00_A5;
  localparam logic [7:0] ADDR_TARGET = 8'h00_A6;
  localparam logic [7:0] ADDR_KEY = 8'h00_C1;
  localparam logic [7:0] ADDR_NOM_TRIM = 8'h00_F6;
  localparam logic [7:0] ADDR_THERM_TRIM = 8'h00_F7;
  localparam logic [7:0] ADDR_PIN_OPT = 8'h00_FF;
  // ----------------------------------------
  // config fields
  // ----------------------------------------
  localparam int BIT_MIDNIGHT = 7;
  localparam int BIT_DAY_WRAP = 6;
  localparam int BIT_BASE_HI = 5;
  localparam int BIT_BASE_LO = 4;
  localparam int BIT_SINGLE = 3;
  localparam int BIT_ALARM = 2;
  localparam int BIT_INT_EN = 1;
  localparam int BIT_KEEP_EN = 0;
  localparam logic [7:0] KEY_TIME_UNLOCK = 8'h00_EA;
  localparam logic [7:0] FRACTION_LAST = 8'h00_7F;
  localparam logic [7:0] MINSEC_LAST = 8'h00_3B;
  localparam logic [7:0] HOUR_LAST_DAY = 8'h00_17;
  localparam logic [7:0] HOUR_LAST_LONG = 8'h00_FF;
  localparam logic [7:0] ZERO_BYTE = 8'h00_00;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int XTAL_HZ = 32768;
  localparam int TICKS_PER_SEC = 128;
  localparam int XTAL_PER_TICK = XTAL_HZ / TICKS_PER_SEC;
  localparam logic [8:0] TICK_RELOAD = 9'(XTAL_PER_TICK - 1);
  localparam int WINDOW_TICKS = 3904;
  localparam logic [11:0] WINDOW_LAST = 12'(WINDOW_TICKS - 1);
  typedef enum logic [1:0] {BASE_TICK, BASE_SEC, BASE_MIN, BASE_HOUR} base_type;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_type;
  typedef struct packed {
    logic tick;
    logic sec;
    logic min;
    logic hour;
  } tick_set_type;
endpackage

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import rtc_pkg::*;
();
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic por_n = 1'b0;
  logic xtal_clk = 1'b0;
  logic [1:0] xdiv = 2'b00;
  sfr_req_type sfr_req = '0;
  logic [7:0] sfr_rdata;
  logic rtc_irq;
  logic strobe_enable;
  int fails = 0;
  int check_count = 0;
  logic [7:0] rv;
  logic [7:0] cfg;
  logic [7:0] hw_cfg [3] = '{8'h01, 8'h01, 8'h41};
  logic [7:0] hw_pre [3] = '{8'h17, 8'hFF, 8'h17};
  logic [7:0] hw_exp [3] = '{8'h18, 8'h00, 8'h00};

  rtc_timekeeper u_dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .por_n(por_n),
    .xtal_clk(xtal_clk),
    .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata),
    .rtc_irq(rtc_irq),
    .strobe_enable(strobe_enable)
  );

  // ----------------------------------------
  // clock and crystal stand-in
  // ----------------------------------------
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    xdiv <= xdiv + 2'b01;
    xtal_clk <= xdiv[1];
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_req <= '{1'b1, a, d};
    @(posedge ref_clk);
    sfr_req.wr <= 1'b0;
  endtask
  task automatic twr(input logic [7:0] a, input logic [7:0] d);
    wr(ADDR_KEY, KEY_TIME_UNLOCK);
    wr(a, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    sfr_req <= '{1'b0, a, ZERO_BYTE};
    @(posedge ref_clk);
    #1 d = sfr_rdata;
  endtask
  task automatic poll(input string name, input logic [7:0] a, input logic [7:0] e, input int n);
    logic [7:0] d;
    d = '0;
    for (int i = 0; i < n; i++) begin
      rd(a, d);
      if (d === e) break;
    end
    chk(name, d, e);
  endtask
  task automatic pulse(input logic por);
    @(posedge ref_clk);
    if (por) por_n <= 1'b0;
    else rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    por_n <= 1'b1;
    rst_n <= 1'b1;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    stop_test();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(ADDR_CONFIG + 8'(i), rv);
      chk("reset value", rv, (i == 0) ? 8'h01 : ZERO_BYTE);
    end
    chk("strobe", 8'(strobe_enable), 8'h01);
    rd(8'hB0, rv);
    chk("unmapped", rv, ZERO_BYTE);
    wr(ADDR_SECONDS, 8'h10);
    rd(ADDR_SECONDS, rv);
    chk("locked write", rv, ZERO_BYTE);
    wr(ADDR_NOM_TRIM, 8'h12);
    rd(ADDR_NOM_TRIM, rv);
    chk("nominal trim", rv, 8'h12);
    wr(ADDR_NOM_TRIM, ZERO_BYTE);
    $display("test access done");
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CONFIG, hw_cfg[i]);
      twr(ADDR_HOURS, hw_pre[i]);
      twr(ADDR_MINUTES, MINSEC_LAST);
      twr(ADDR_SECONDS, MINSEC_LAST);
      twr(ADDR_FRACTION, FRACTION_LAST);
      poll("hour wrap", ADDR_HOURS, hw_exp[i], 1500);
      rd(ADDR_MINUTES, rv);
      chk("minute wrap", rv, ZERO_BYTE);
      rd(ADDR_SECONDS, rv);
      chk("second wrap", rv, ZERO_BYTE);
      rd(ADDR_CONFIG, rv);
      chk("midnight", rv, hw_cfg[i] | {hw_exp[i] == 8'h00, 7'h00});
      chk("irq", 8'(rtc_irq), 8'(hw_exp[i] == 8'h00));
    end
    wr(ADDR_CONFIG, 8'h41);
    rd(ADDR_CONFIG, rv);
    chk("midnight clear", rv, 8'h41);
    chk("irq clear", 8'(rtc_irq), 8'h00);
    $display("test wrap done");
    twr(ADDR_HOURS, 8'h05);
    pulse(1'b0);
    rd(ADDR_HOURS, rv);
    chk("hours kept", rv, 8'h05);
    rd(ADDR_CONFIG, rv);
    chk("wrap mode kept", rv, 8'h41);
    pulse(1'b1);
    rd(ADDR_HOURS, rv);
    chk("hours cleared", rv, ZERO_BYTE);
    rd(ADDR_CONFIG, rv);
    chk("wrap mode cleared", rv, 8'h01);
    $display("test reset done");
    wr(ADDR_TARGET, 8'h01);
    for (int b = 0; b < 4; b++) begin
      cfg = 8'h03 | 8'(b << 4);
      wr(ADDR_CONFIG, cfg);
      if (b == 3) twr(ADDR_MINUTES, MINSEC_LAST);
      if (b >= 2) twr(ADDR_SECONDS, MINSEC_LAST);
      if (b >= 1) twr(ADDR_FRACTION, FRACTION_LAST);
      poll("base alarm", ADDR_CONFIG, cfg | 8'h04, 1500);
      chk("alarm irq", 8'(rtc_irq), 8'h01);
      wr(ADDR_CONFIG, 8'h01);
    end
    wr(ADDR_TARGET, 8'h02);
    wr(ADDR_CONFIG, 8'h0B);
    poll("single alarm", ADDR_CONFIG, 8'h0F, 3000);
    wr(ADDR_CONFIG, 8'h0B);
    repeat (4000) @(posedge ref_clk);
    rd(ADDR_CONFIG, rv);
    chk("single stops", rv, 8'h0B);
    wr(ADDR_CONFIG, 8'h01);
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CONFIG, 8'h03);
      poll("repeat alarm", ADDR_CONFIG, 8'h07, 3000);
    end
    $display("test interval done");
    wr(ADDR_TARGET, 8'h01);
    for (int i = 1; i < 3; i++) begin
      wr(ADDR_CONFIG, 8'(i));
      repeat (3000) @(posedge ref_clk);
      rd(ADDR_CONFIG, rv);
      chk("no alarm", rv, 8'(i));
      chk("strobe follow", 8'(strobe_enable), 8'(i & 1));
    end
    $display("test disable done");
    stop_test();
  end
endmodule

/* verilog/rtc_timekeeper.sv */
`timescale 1ns/1ps
module rtc_timekeeper
  import rtc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic xtal_clk,
  input wire sfr_req_type sfr_req,
  output logic [7:0] sfr_rdata,
  output logic rtc_irq,
  output logic strobe_enable
);
  // ----------------------------------------
  // crystal edge sync
  // ----------------------------------------
  logic xs1_ff, xs2_ff, xs3_ff;
  always_ff @(posedge ref_clk) begin
    xs1_ff <= xtal_clk;
    xs2_ff <= xs1_ff;
    xs3_ff <= xs2_ff;
  end
  wire xtal_edge = xs2_ff & ~xs3_ff;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] frac_ff, sec_ff, min_ff, hour_ff, target_ff, key_ff;
  logic [7:0] nom_trim_ff, therm_trim_ff, pin_opt_ff, icount_ff;
  logic midnight_ff, alarm_ff, day_wrap_ff, single_ff, int_en_ff, keep_en_ff;
  logic [1:0] base_ff;
  logic shot_done_ff;
  logic [8:0] div_ff;
  logic [11:0] win_ff;
  logic [7:0] corr_ff;
  logic corr_neg_ff;

  wire wr_cfg = sfr_req.wr & (sfr_req.addr == ADDR_CONFIG);
  wire unlocked = key_ff == KEY_TIME_UNLOCK;
  wire wr_time = sfr_req.wr & unlocked &
    ((sfr_req.addr == ADDR_FRACTION) | (sfr_req.addr == ADDR_SECONDS) |
     (sfr_req.addr == ADDR_MINUTES) | (sfr_req.addr == ADDR_HOURS));

  // ----------------------------------------
  // calibrated tick
  // ----------------------------------------
  wire [8:0] trim_sum = {nom_trim_ff[7], nom_trim_ff} + {therm_trim_ff[7], therm_trim_ff};
  wire adjust_now = (corr_ff != ZERO_BYTE) & (div_ff == 9'h0_000);
  wire [8:0] reload = !adjust_now ? TICK_RELOAD :
    (corr_neg_ff ? TICK_RELOAD + 9'h0_001 : TICK_RELOAD - 9'h0_001);
  wire tick = xtal_edge & (div_ff == 9'h0_000);
  always_ff @(posedge ref_clk) begin
    if (!por_n) begin
      div_ff <= TICK_RELOAD;
      win_ff <= 12'h0_000;
      corr_ff <= ZERO_BYTE;
      corr_neg_ff <= 1'b0;
    end else if (xtal_edge) begin
      div_ff <= (div_ff == 9'h0_000) ? reload : div_ff - 9'h0_001;
      if (tick) begin
        if (win_ff == WINDOW_LAST) begin
          win_ff <= 12'h0_000;
          corr_neg_ff <= trim_sum[8];
          corr_ff <= trim_sum[8] ? 8'(-trim_sum) : trim_sum[7:0];
        end else begin
          win_ff <= win_ff + 12'h0_001;
          if (adjust_now) corr_ff <= corr_ff - 8'h00_01;
        end
      end
    end
  end

  // ----------------------------------------
  // time cascade
  // ----------------------------------------
  wire frac_wrap = tick & (frac_ff == FRACTION_LAST);
  wire sec_wrap = frac_wrap & (sec_ff == MINSEC_LAST);
  wire min_wrap = sec_wrap & (min_ff == MINSEC_LAST);
  wire [7:0] hour_last = day_wrap_ff ? HOUR_LAST_DAY : HOUR_LAST_LONG;
  wire hour_wrap = min_wrap & (hour_ff == hour_last);
  always_ff @(posedge ref_clk) begin
    if (!por_n) begin
      frac_ff <= ZERO_BYTE;
      sec_ff <= ZERO_BYTE;
      min_ff <= ZERO_BYTE;
      hour_ff <= ZERO_BYTE;
    end else if (wr_time) begin
      if (sfr_req.addr == ADDR_FRACTION) frac_ff <= sfr_req.wdata;
      if (sfr_req.addr == ADDR_SECONDS) sec_ff <= sfr_req.wdata;
      if (sfr_req.addr == ADDR_MINUTES) min_ff <= sfr_req.wdata;
      if (sfr_req.addr == ADDR_HOURS) hour_ff <= sfr_req.wdata;
    end else if (tick) begin
      frac_ff <= frac_wrap ? ZERO_BYTE : frac_ff + 8'h00_01;
      if (frac_wrap) sec_ff <= sec_wrap ? ZERO_BYTE : sec_ff + 8'h00_01;
      if (sec_wrap) min_ff <= min_wrap ? ZERO_BYTE : min_ff + 8'h00_01;
      if (min_wrap) hour_ff <= hour_wrap ? ZERO_BYTE : hour_ff + 8'h00_01;
    end
  end

  // ----------------------------------------
  // interval timer
  // ----------------------------------------
  tick_set_type bases;
  assign bases = '{tick: tick, sec: frac_wrap, min: sec_wrap, hour: min_wrap};
  wire base_tick = (base_ff == BASE_TICK) ? bases.tick :
                   (base_ff == BASE_SEC) ? bases.sec :
                   (base_ff == BASE_MIN) ? bases.min : bases.hour;
  wire int_run = int_en_ff & keep_en_ff & ~shot_done_ff;
  wire [7:0] nxt_icount = icount_ff + 8'h00_01;
  wire int_hit = int_run & base_tick & (nxt_icount == target_ff);
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !int_en_ff) begin
      icount_ff <= ZERO_BYTE;
      shot_done_ff <= 1'b0;
    end else if (int_run && base_tick) begin
      icount_ff <= int_hit ? ZERO_BYTE : nxt_icount;
      if (int_hit && single_ff) shot_done_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // config and trims
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!por_n) day_wrap_ff <= 1'b0;
    else if (wr_cfg) day_wrap_ff <= sfr_req.wdata[BIT_DAY_WRAP];
  end
  always_ff @(posedge ref_clk) begin
    if (!por_n || !rst_n) begin
      midnight_ff <= 1'b0;
      alarm_ff <= 1'b0;
      base_ff <= BASE_TICK;
      single_ff <= 1'b0;
      int_en_ff <= 1'b0;
      keep_en_ff <= 1'b1;
      target_ff <= ZERO_BYTE;
      key_ff <= ZERO_BYTE;
      nom_trim_ff <= ZERO_BYTE;
      therm_trim_ff <= ZERO_BYTE;
      pin_opt_ff <= ZERO_BYTE;
    end else begin
      midnight_ff <= hour_wrap | (midnight_ff &
        ~(wr_cfg & ~sfr_req.wdata[BIT_MIDNIGHT]));
      alarm_ff <= int_hit | (alarm_ff & ~(wr_cfg & ~sfr_req.wdata[BIT_ALARM]));
      if (wr_cfg) begin
        base_ff <= sfr_req.wdata[BIT_BASE_HI:BIT_BASE_LO];
        single_ff <= sfr_req.wdata[BIT_SINGLE];
        int_en_ff <= sfr_req.wdata[BIT_INT_EN];
        keep_en_ff <= sfr_req.wdata[BIT_KEEP_EN];
      end
      if (sfr_req.wr && sfr_req.addr == ADDR_TARGET) target_ff <= sfr_req.wdata;
      if (sfr_req.wr && sfr_req.addr == ADDR_KEY) key_ff <= sfr_req.wdata;
      else if (sfr_req.wr) key_ff <= ZERO_BYTE;
      if (sfr_req.wr && sfr_req.addr == ADDR_NOM_TRIM) nom_trim_ff <= sfr_req.wdata;
      if (sfr_req.wr && sfr_req.addr == ADDR_THERM_TRIM) therm_trim_ff <= sfr_req.wdata;
      if (sfr_req.wr && sfr_req.addr == ADDR_PIN_OPT) pin_opt_ff <= sfr_req.wdata;
    end
  end

  // ----------------------------------------
  // read mux and outputs
  // ----------------------------------------
  wire [7:0] cfg_view = {midnight_ff, day_wrap_ff, base_ff, single_ff,
                         alarm_ff, int_en_ff, keep_en_ff};
  wire [7:0] rd_mux =
    (sfr_req.addr == ADDR_CONFIG) ? cfg_view :
    (sfr_req.addr == ADDR_FRACTION) ? frac_ff :
    (sfr_req.addr == ADDR_SECONDS) ? sec_ff :
    (sfr_req.addr == ADDR_MINUTES) ? min_ff :
    (sfr_req.addr == ADDR_HOURS) ? hour_ff :
    (sfr_req.addr == ADDR_TARGET) ? target_ff :
    (sfr_req.addr == ADDR_KEY) ? key_ff :
    (sfr_req.addr == ADDR_NOM_TRIM) ? nom_trim_ff :
    (sfr_req.addr == ADDR_THERM_TRIM) ? therm_trim_ff :
    (sfr_req.addr == ADDR_PIN_OPT) ? pin_opt_ff : ZERO_BYTE;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sfr_rdata <= ZERO_BYTE;
      rtc_irq <= 1'b0;
      strobe_enable <= 1'b0;
    end else begin
      sfr_rdata <= rd_mux;
      rtc_irq <= midnight_ff | alarm_ff;
      strobe_enable <= keep_en_ff;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_midnight_set: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    hour_wrap |=> midnight_ff) else $error("midnight flag not set");
  a_alarm_set: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    int_hit |=> alarm_ff) else $error("alarm flag not set");
  a_hold_zero: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    !int_en_ff |=> icount_ff == ZERO_BYTE) else $error("count not held");
  a_run_gate: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    !keep_en_ff && int_en_ff |=> $stable(icount_ff)) else $error("timer ran disabled");
  a_frac_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    frac_wrap && !wr_time |=> frac_ff == ZERO_BYTE) else $error("fraction wrap");
  a_sec_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    sec_wrap && !wr_time |=> sec_ff == ZERO_BYTE && min_ff != $past(min_ff))
    else $error("second wrap");
  a_hour_day: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    day_wrap_ff && !wr_time |-> hour_ff <= HOUR_LAST_DAY || $past(wr_time))
    else $error("hour past 23");
  a_irq_follow: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    hour_wrap |-> ##2 rtc_irq) else $error("irq missing");
  a_single_stop: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    int_hit && single_ff |=> !int_run) else $error("single shot rerun");

  // ----------------------------------------
  // time cascade checks
  // ----------------------------------------
  a_frac_step: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    tick && !frac_wrap && !wr_time
    |=> frac_ff == $past(frac_ff) + 8'h00_01)
    else $error("fraction step");
  a_frac_hold: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    !tick && !wr_time
    |=> $stable(frac_ff))
    else $error("fraction moved without tick");
  a_sec_step: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    frac_wrap && !sec_wrap && !wr_time
    |=> sec_ff == $past(sec_ff) + 8'h00_01)
    else $error("second step");
  a_sec_hold: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    !frac_wrap && !wr_time
    |=> $stable(sec_ff))
    else $error("second moved early");
  a_min_step: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    sec_wrap && !min_wrap && !wr_time
    |=> min_ff == $past(min_ff) + 8'h00_01)
    else $error("minute step");
  a_min_hold: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    !sec_wrap && !wr_time
    |=> $stable(min_ff))
    else $error("minute moved early");
  a_min_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    min_wrap && !wr_time
    |=> min_ff == ZERO_BYTE)
    else $error("minute wrap");
  a_hour_step: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    min_wrap && !hour_wrap && !wr_time
    |=> hour_ff == $past(hour_ff) + 8'h00_01)
    else $error("hour step");
  a_hour_hold: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    !min_wrap && !wr_time
    |=> $stable(hour_ff))
    else $error("hour moved early");
  a_hour_zero: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    hour_wrap && !wr_time
    |=> hour_ff == ZERO_BYTE)
    else $error("hour wrap");
  a_hour_long: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    min_wrap && !day_wrap_ff && !wr_time && hour_ff == HOUR_LAST_DAY
    |=> hour_ff == HOUR_LAST_DAY + 8'h00_01)
    else $error("long mode wrapped at 23");
  a_wrap_keep: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    !wr_cfg
    |=> $stable(day_wrap_ff))
    else $error("wrap mode moved");

  // ----------------------------------------
  // divider checks
  // ----------------------------------------
  a_tick_gap: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    tick
    |=> !tick)
    else $error("tick twice in a row");
  a_div_step: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    xtal_edge && div_ff != 9'h0_000
    |=> div_ff == $past(div_ff) - 9'h0_001)
    else $error("divider step");
  a_div_hold: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    !xtal_edge
    |=> $stable(div_ff))
    else $error("divider moved without edge");
  a_div_reload: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    xtal_edge && div_ff == 9'h0_000 && !adjust_now
    |=> div_ff == TICK_RELOAD)
    else $error("divider reload");
  a_corr_range: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    xtal_edge && adjust_now
    |=> div_ff == TICK_RELOAD + 9'h0_001 || div_ff == TICK_RELOAD - 9'h0_001)
    else $error("trim step out of range");
  a_win_step: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    tick && win_ff != WINDOW_LAST
    |=> win_ff == $past(win_ff) + 12'h0_001)
    else $error("window step");
  a_win_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    tick && win_ff == WINDOW_LAST
    |=> win_ff == 12'h0_000)
    else $error("window wrap");

  // ----------------------------------------
  // interval checks
  // ----------------------------------------
  a_count_step: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    int_run && base_tick && !int_hit
    |=> icount_ff == $past(icount_ff) + 8'h00_01)
    else $error("interval step");
  a_count_restart: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    int_hit
    |=> icount_ff == ZERO_BYTE)
    else $error("interval restart");
  a_count_idle: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    int_en_ff && !(int_run && base_tick)
    |=> $stable(icount_ff))
    else $error("interval moved idle");
  a_shot_hold: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    shot_done_ff && int_en_ff
    |=> shot_done_ff)
    else $error("single shot rearmed");
  a_repeat_run: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    int_hit && !single_ff
    |=> !shot_done_ff)
    else $error("repeat mode stopped");
  a_target_load: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    sfr_req.wr && sfr_req.addr == ADDR_TARGET
    |=> target_ff == $past(sfr_req.wdata))
    else $error("target not loaded");

  // ----------------------------------------
  // flag checks
  // ----------------------------------------
  a_alarm_hold: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    alarm_ff && !wr_cfg
    |=> alarm_ff)
    else $error("alarm dropped");
  a_alarm_clear: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    wr_cfg && !sfr_req.wdata[BIT_ALARM] && !int_hit
    |=> !alarm_ff)
    else $error("alarm not cleared");
  a_alarm_cause: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    !alarm_ff && !int_hit
    |=> !alarm_ff)
    else $error("alarm without hit");
  a_mid_hold: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    midnight_ff && !wr_cfg
    |=> midnight_ff)
    else $error("midnight dropped");
  a_mid_clear: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    wr_cfg && !sfr_req.wdata[BIT_MIDNIGHT] && !hour_wrap
    |=> !midnight_ff)
    else $error("midnight not cleared");
  a_mid_cause: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    !midnight_ff && !hour_wrap
    |=> !midnight_ff)
    else $error("midnight without wrap");

  // ----------------------------------------
  // output and key checks
  // ----------------------------------------
  a_irq_alarm: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    alarm_ff
    |=> rtc_irq)
    else $error("irq missing for alarm");
  a_irq_mid: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    midnight_ff
    |=> rtc_irq)
    else $error("irq missing for midnight");
  a_irq_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    !alarm_ff && !midnight_ff
    |=> !rtc_irq)
    else $error("irq without flag");
  a_strobe_on: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    keep_en_ff
    |=> strobe_enable)
    else $error("strobe enable low");
  a_strobe_off: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    !keep_en_ff
    |=> !strobe_enable)
    else $error("strobe enable high");
  a_key_clear: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    sfr_req.wr && sfr_req.addr != ADDR_KEY
    |=> key_ff == ZERO_BYTE)
    else $error("key not cleared");
  a_locked_sec: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    sfr_req.wr && !unlocked && sfr_req.addr == ADDR_SECONDS && !frac_wrap
    |=> $stable(sec_ff))
    else $error("locked write landed");
  a_trim_load: assert property (@(posedge ref_clk) disable iff (!rst_n || !por_n)
    sfr_req.wr && sfr_req.addr == ADDR_NOM_TRIM
    |=> nom_trim_ff == $past(sfr_req.wdata))
    else $error("trim not loaded");
endmodule
